/* design/spi_guard_pkg.sv */
// Purpose: Shared constants and types for the SPI nonvolatile memory slave
// Assumes: SPI modes 0 and 3, 512-byte array, 8-bit status register
// Notes:   Opcode values are full bytes except the memory opcodes carrying A8
package spi_guard_pkg;

   // ----------------------------------------
   // Opcodes
   // ----------------------------------------
   localparam logic [7:0] OPC_ARM_WRITES    = 8'h06;
   localparam logic [7:0] OPC_DISARM_WRITES = 8'h04;
   localparam logic [7:0] OPC_STATUS_FETCH  = 8'h05;
   localparam logic [7:0] OPC_STATUS_WRITE  = 8'h01;
   localparam logic [2:0] OPC_READ_LOW      = 3'h3;
   localparam logic [2:0] OPC_WRITE_LOW     = 3'h2;
   localparam int         OPC_ADDR_BIT      = 3;

   // ----------------------------------------
   // Status register layout and reset values
   // ----------------------------------------
   localparam int         STAT_LATCH_BIT    = 1;
   localparam int         STAT_GUARD_LO_BIT = 2;
   localparam int         STAT_GUARD_HI_BIT = 3;
   localparam logic [1:0] GUARD_FACTORY     = 2'h0;
   localparam logic       LATCH_RESET       = 1'b0;

   // ----------------------------------------
   // Address map
   // ----------------------------------------
   localparam int         ADDR_W            = 9;
   localparam logic [8:0] GUARD_QUARTER     = 9'h180;
   localparam logic [8:0] GUARD_HALF        = 9'h100;
   localparam logic [2:0] BYTE_LAST_BIT     = 3'h7;

   // ----------------------------------------
   // Frame states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_OPCODE  = 3'b000,
      ST_ADDR_RD = 3'b001,
      ST_ADDR_WR = 3'b010,
      ST_RDATA   = 3'b011,
      ST_WDATA   = 3'b100,
      ST_SFETCH  = 3'b101,
      ST_SWRITE  = 3'b110,
      ST_IGNORE  = 3'b111
   } frame_state_e;

endpackage

/* design/sync2.sv */
// Purpose: Two-flop synchroniser for a single level
// Assumes: Destination clock may stop; output follows only on its edges
// Notes:   First stage is read by the second stage only
`timescale 1ns/1ps
module sync2 #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic d,
   output logic      q
);
   logic meta;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

/* design/spi_guard_mem.sv */
// Purpose: SPI slave command logic of a 512-byte nonvolatile memory with write protection
// Assumes: SCK is the link clock; CLOCK hosts the write latch flag
// Notes:   Array and guard bits have no reset, they model retained storage
//
// Function
// R1: Writes refused while write latch flag clear
// R2: Low write-protect pin blocks all writes
// R3: Armed and unprotected: writes outside guarded range
// R4: Status bits 0 and 4-7 read zero
// R5: Status bit1 latch, bit2/3 guard bits
// R6: Write latch flag clear after power-up
// R7: Only the arm opcode sets latch flag
// R8: Guard bits retained, factory value zero
// R9: Guard codes select none, quarter, half, all
// R10: Status update needs latch set, pin high
// R11: Master arms earlier and holds pin high
// R12: Status fetch returns one status byte
// R13: Completed status write clears latch flag
// R14: Opcode bit3 is A8, next byte A7-A0
// R15: Burst address increments, wraps 1FFh to 000h
// R16: Each data byte committed at eighth bit
// R17: Guarded address stops burst, discards data
// R18: Chip select rise ends write command
// R19: Read drives data bytes, ignores SI
// R20: Chip select rise ends read, releases SO
// R21: Data shifted most significant bit first
// R22: Decode the six command byte encodings
// R23: Latch cleared at rise after disarm/writes
// R24: Unknown opcode ignored until next select
// R25: Sample rising SCK, drive falling SCK
// R26: Status write changes guard bits only
`timescale 1ns/1ps
module spi_guard_mem
   import spi_guard_pkg::*;
(
   input  wire logic CLOCK,
   input  wire logic NRST,
   input  wire logic SCK,
   input  wire logic CS_N,
   input  wire logic SI,
   input  wire logic WP_N,
   output logic      SO,
   output logic      SO_OE
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0]        mem [0:(1<<ADDR_W)-1];
   logic [1:0]        block_guard = GUARD_FACTORY;
   frame_state_e      state;
   logic [2:0]        cnt;
   logic [6:0]        rx;
   logic [7:0]        next_rx;
   logic [7:0]        tx;
   logic [8:0]        addr;
   logic              byte_done;
   logic              frame_rst_n;
   logic              arm_tgl;
   logic              clr_tgl;
   logic              wel_s;
   logic              wp_s;
   logic              write_ok;
   logic              guard_ok;
   logic              mem_we;
   logic [7:0]        status_byte;
   logic              out_active;
   logic              write_latch_flag;
   logic              clr_pend;
   logic              cs_s;
   logic              cs_d;
   logic              arm_s;
   logic              arm_d;
   logic              clr_s;
   logic              clr_d;
   logic              arm_evt;
   logic              clr_evt;
   logic              cs_rise;

   function automatic logic guarded(input logic [8:0] a, input logic [1:0] bg);
      logic hit;
      hit = 1'b0;
      unique case (bg)                                            // see R9
         2'h0: hit = 1'b0;
         2'h1: hit = (a >= GUARD_QUARTER);
         2'h2: hit = (a >= GUARD_HALF);
         2'h3: hit = 1'b1;
      endcase
      return hit;
   endfunction

   // ----------------------------------------
   // Link domain: framing and shifting
   // ----------------------------------------
   // Chip select high holds the frame logic in reset, so no SCK edge is needed to end a frame
   assign frame_rst_n = NRST & ~CS_N;
   assign next_rx     = {rx, SI};                                 // see R21
   assign byte_done   = (cnt == BYTE_LAST_BIT);

   sync2 #(.RST_VAL(LATCH_RESET)) u_wel_sync (
      .clk   (SCK),
      .rst_n (NRST),
      .d     (write_latch_flag),
      .q     (wel_s)
   );

   // Pin held low at reset so nothing writes before it is seen high
   sync2 #(.RST_VAL(1'b0)) u_wp_sync (
      .clk   (SCK),
      .rst_n (NRST),
      .d     (WP_N),
      .q     (wp_s)
   );

   always_ff @(posedge SCK or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         cnt <= 3'h0;
         rx  <= 7'h00;
      end else begin
         cnt <= cnt + 3'h1;                                       // see R25
         rx  <= next_rx[6:0];
      end
   end

   assign guard_ok = !guarded(addr, block_guard);
   assign write_ok = wel_s && wp_s && guard_ok;                   // see R1 see R2 see R3
   assign mem_we   = (state == ST_WDATA) && byte_done && write_ok;

   assign status_byte = {4'h0, block_guard[1], block_guard[0], wel_s, 1'b0}; // see R4 see R5

   always_ff @(posedge SCK or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         state <= ST_OPCODE;
      end else if (byte_done) begin
         unique case (state)
            ST_OPCODE: begin
               if (next_rx[7:4] == 4'h0 && next_rx[2:0] == OPC_READ_LOW) begin
                  state <= ST_ADDR_RD;                            // see R22
               end else if (next_rx[7:4] == 4'h0 && next_rx[2:0] == OPC_WRITE_LOW) begin
                  state <= ST_ADDR_WR;
               end else if (next_rx == OPC_STATUS_FETCH) begin
                  state <= ST_SFETCH;
               end else if (next_rx == OPC_STATUS_WRITE) begin
                  state <= ST_SWRITE;
               end else begin
                  state <= ST_IGNORE;                             // see R24
               end
            end
            ST_ADDR_RD: state <= ST_RDATA;
            ST_ADDR_WR: state <= ST_WDATA;
            ST_RDATA:   state <= ST_RDATA;
            ST_WDATA:   state <= write_ok ? ST_WDATA : ST_IGNORE; // see R17
            ST_SFETCH:  state <= ST_IGNORE;
            ST_SWRITE:  state <= ST_IGNORE;
            ST_IGNORE:  state <= ST_IGNORE;
         endcase
      end
   end

   // ----------------------------------------
   // Link domain: address and transmit byte
   // ----------------------------------------
   always_ff @(posedge SCK or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         addr <= 9'h000;
         tx   <= 8'h00;
      end else if (byte_done) begin
         if (state == ST_OPCODE) begin
            addr[8] <= next_rx[OPC_ADDR_BIT];                     // see R14
            if (next_rx == OPC_STATUS_FETCH) begin
               tx <= status_byte;                                 // see R12
            end
         end else if (state == ST_ADDR_RD) begin
            tx   <= mem[{addr[8], next_rx}];                      // see R19
            addr <= {addr[8], next_rx} + 9'h001;
         end else if (state == ST_ADDR_WR) begin
            addr[7:0] <= next_rx;                                 // see R14
         end else if (state == ST_RDATA) begin
            tx   <= mem[addr];
            addr <= addr + 9'h001;                                // see R15
         end else if (mem_we) begin
            addr <= addr + 9'h001;                                // see R15
         end
      end
   end

   // No page buffer: the byte goes straight into the array on its last bit
   always_ff @(posedge SCK) begin
      if (mem_we) begin
         mem[addr] <= next_rx;                                    // see R16
      end
   end

   // Only the guard positions are taken; latch and reserved positions are dropped
   always_ff @(posedge SCK) begin
      if (state == ST_SWRITE && byte_done && wel_s && wp_s) begin
         block_guard <= next_rx[STAT_GUARD_HI_BIT:STAT_GUARD_LO_BIT]; // see R10 see R26 see R8
      end
   end

   // Command outcome events, kept across frames so they survive chip select
   always_ff @(posedge SCK or negedge NRST) begin
      if (!NRST) begin
         arm_tgl <= 1'b0;
         clr_tgl <= 1'b0;
      end else if (state == ST_OPCODE && byte_done && frame_rst_n) begin
         if (next_rx == OPC_ARM_WRITES) begin
            arm_tgl <= ~arm_tgl;                                  // see R7
         end
         if (next_rx == OPC_DISARM_WRITES || next_rx == OPC_STATUS_WRITE ||
             (next_rx[7:4] == 4'h0 && next_rx[2:0] == OPC_WRITE_LOW)) begin
            clr_tgl <= ~clr_tgl;                                  // see R23
         end
      end
   end

   // ----------------------------------------
   // Link domain: serial output
   // ----------------------------------------
   always_ff @(negedge SCK or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         SO         <= 1'b0;
         out_active <= 1'b0;
      end else begin
         out_active <= (state == ST_RDATA) || (state == ST_SFETCH);
         // Outside a data phase the line rests at zero instead of leaking stale status bits
         if ((state == ST_RDATA) || (state == ST_SFETCH)) begin
            SO <= tx[~cnt];                                       // see R21 see R25
         end else begin
            SO <= 1'b0;
         end
      end
   end

   assign SO_OE = out_active & ~CS_N;                             // see R20 see R24

   // ----------------------------------------
   // System domain: write latch flag
   // ----------------------------------------
   sync2 #(.RST_VAL(1'b1)) u_cs_sync (
      .clk   (CLOCK),
      .rst_n (NRST),
      .d     (CS_N),
      .q     (cs_s)
   );

   sync2 #(.RST_VAL(1'b0)) u_arm_sync (
      .clk   (CLOCK),
      .rst_n (NRST),
      .d     (arm_tgl),
      .q     (arm_s)
   );

   sync2 #(.RST_VAL(1'b0)) u_clr_sync (
      .clk   (CLOCK),
      .rst_n (NRST),
      .d     (clr_tgl),
      .q     (clr_s)
   );

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         cs_d  <= 1'b1;
         arm_d <= 1'b0;
         clr_d <= 1'b0;
      end else begin
         cs_d  <= cs_s;
         arm_d <= arm_s;
         clr_d <= clr_s;
      end
   end

   assign arm_evt = arm_s ^ arm_d;
   assign clr_evt = clr_s ^ clr_d;
   assign cs_rise = cs_s & ~cs_d;

   // Both paths have equal sync depth, so a clear event is never later than its frame end
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         clr_pend <= 1'b0;
      end else if (cs_rise) begin
         clr_pend <= 1'b0;
      end else if (clr_evt) begin
         clr_pend <= 1'b1;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         write_latch_flag <= LATCH_RESET;                         // see R6
      end else if (arm_evt) begin
         write_latch_flag <= 1'b1;                                // see R7
      end else if (cs_rise && (clr_pend || clr_evt)) begin
         write_latch_flag <= 1'b0;                                // see R13 see R18 see R23
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_pin_blocks_write: assert property (@(posedge SCK) disable iff (!frame_rst_n) // see R2
      mem_we |-> WP_N && write_latch_flag)
      else $error("array written while pin low or latch clear");

   a_guard_range: assert property (@(posedge SCK) disable iff (!frame_rst_n) // see R3
      mem_we |-> !(block_guard == 2'h3 || (block_guard == 2'h2 && addr[8]) ||
                   (block_guard == 2'h1 && addr[8] && addr[7])))
      else $error("write landed in guarded range");

   a_status_gate: assert property (@(posedge SCK) disable iff (!frame_rst_n) // see R10
      (state == ST_SWRITE && byte_done && !(wel_s && wp_s)) |=> $stable(block_guard))
      else $error("status changed without permission");

   a_burst_wrap: assert property (@(posedge SCK) disable iff (!frame_rst_n) // see R15
      (mem_we && addr == 9'h1FF) |=> addr == 9'h000)
      else $error("address did not wrap to zero");

   a_burst_stop: assert property (@(posedge SCK) disable iff (!frame_rst_n) // see R17
      (state == ST_WDATA && byte_done && !write_ok) |=> state == ST_IGNORE ##1 $stable(addr))
      else $error("burst continued into guarded block");

   a_fetch_bits: assert property (@(negedge SCK) disable iff (!frame_rst_n) // see R12
      (state == ST_SFETCH && cnt == 3'h0) |=> SO == tx[7] && out_active)
      else $error("status byte msb not driven");

   a_latch_arm: assert property (@(posedge CLOCK) disable iff (!NRST) // see R7
      arm_evt |=> write_latch_flag ##1 (write_latch_flag || cs_rise))
      else $error("arm command did not set latch");

   a_latch_clear: assert property (@(posedge CLOCK) disable iff (!NRST) // see R23
      (cs_rise && (clr_pend || clr_evt) && !arm_evt) |=> !write_latch_flag)
      else $error("latch not cleared at frame end");

   a_so_release: assert property (@(posedge CLOCK) disable iff (!NRST) // see R20
      CS_N |-> !SO_OE && !out_active && !SO)
      else $error("output driven while deselected");

   a_ignore_quiet: assert property (@(negedge SCK) disable iff (!frame_rst_n) // see R24
      (state == ST_IGNORE) |=> !out_active)
      else $error("output enabled in ignored frame");

   c_burst_write: cover property (@(posedge SCK) disable iff (!frame_rst_n)
      mem_we ##8 mem_we);

   c_status_fetch: cover property (@(negedge SCK) disable iff (!frame_rst_n)
      state == ST_SFETCH && out_active);

   c_guard_set: cover property (@(posedge SCK) disable iff (!frame_rst_n)
      state == ST_SWRITE && byte_done && wel_s && wp_s);

endmodule

/* verif/spi_host_model.sv */
// Purpose: Behavioural SPI bus master facing the memory slave
// Assumes: Modes 0 and 3, SCK period 6 ns, SCK parked at its idle level between frames
// Notes:   Reports a captured byte with its output-enable summary on rx_stb
`timescale 1ns/1ps
module spi_host_model (
   output logic       SCK,
   output logic       CS_N,
   output logic       SI,
   input  wire logic  SO,
   input  wire logic  SO_OE,
   output logic [8:0] rx,
   output logic       rx_stb
);
   // ----------------------------------------
   // Bus idle state
   // ----------------------------------------
   logic cpol;

   initial begin
      cpol   = 1'b0;
      SCK    = 1'b0;
      CS_N   = 1'b1;
      SI     = 1'b0;
      rx     = '0;
      rx_stb = 1'b0;
   end

   // ----------------------------------------
   // Frame and byte tasks
   // ----------------------------------------
   // Only called while deselected, so the idle level change is no clock edge for a frame
   task automatic set_mode(input logic m);
      cpol = m;
      SCK  = m;
      #6;
   endtask

   task automatic open_frame();
      CS_N = 1'b0;
      #3;
   endtask

   // Gap covers the latch crossing into the system clock domain
   task automatic close_frame();
      #3;
      CS_N = 1'b1;
      SI   = ~SI;
      #48;
   endtask

   task automatic shift(input logic [7:0] tx, input logic report);
      logic [7:0] b;
      logic       oe;
      oe = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         if (cpol) SCK = 1'b0;
         SI = tx[i];
         #3;
         SCK  = 1'b1;
         b[i] = SO;
         oe   = oe & SO_OE;
         #3;
         if (!cpol) SCK = 1'b0;
      end
      if (report) begin
         rx     = {oe, b};
         rx_stb = 1'b1;
         #1;
         rx_stb = 1'b0;
      end
   endtask
endmodule

/* verif/testbench.sv */
// Purpose: Self-checking bench for the SPI guarded memory slave
// Assumes: Shadow model of array, latch and guard bits kept here
// Notes:   Expected bytes queued by the driver, popped by the monitor
`timescale 1ns/1ps
module testbench;
   import spi_guard_pkg::*;

   logic        CLOCK;
   logic        NRST;
   logic        WP_N;
   logic        SCK;
   logic        CS_N;
   logic        SI;
   logic        SO;
   logic        SO_OE;
   logic [8:0]  rx;
   logic        rx_stb;
   logic [7:0]  shadow [512];
   logic [8:0]  exp_q [$];
   logic [31:0] seed;
   logic        latch;
   logic [1:0]  guard;
   int          n_fail;
   int          checked;

   spi_guard_mem DUT (.CLOCK(CLOCK), .NRST(NRST), .SCK(SCK), .CS_N(CS_N), .SI(SI), .WP_N(WP_N),
                      .SO(SO), .SO_OE(SO_OE));
   spi_host_model host (.SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(SO), .SO_OE(SO_OE), .rx(rx), .rx_stb(rx_stb));

   // ----------------------------------------
   // Clock and reset
   // ----------------------------------------
   initial begin
      CLOCK = 1'b0;
      forever #4 CLOCK = ~CLOCK;
   end

   initial begin
      NRST = 1'b0;
      WP_N = 1'b1;
      repeat (10) @(posedge CLOCK);
      @(negedge CLOCK) NRST = 1'b1;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction

   function automatic logic guarded(input logic [8:0] a);
      case (guard)
         2'h0: return 1'b0;
         2'h1: return a >= GUARD_QUARTER;
         2'h2: return a >= GUARD_HALF;
         default: return 1'b1;
      endcase
   endfunction

   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      if (exp_q.size() != 0) n_fail++;
      if (n_fail == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic cmd(input logic [7:0] op);
      host.open_frame();
      host.shift(op, 1'b0);
      host.close_frame();
      if (op == OPC_ARM_WRITES) latch = 1'b1;
      if (op == OPC_DISARM_WRITES) latch = 1'b0;
   endtask

   // Second byte must come back released and zero
   task automatic fetch();
      exp_q.push_back({1'b1, 4'h0, guard, latch, 1'b0});
      exp_q.push_back(9'h000);
      host.open_frame();
      host.shift(OPC_STATUS_FETCH, 1'b0);
      host.shift(rnd(), 1'b1);
      host.shift(rnd(), 1'b1);
      host.close_frame();
   endtask

   task automatic swrite(input logic [7:0] b);
      host.open_frame();
      host.shift(OPC_STATUS_WRITE, 1'b0);
      host.shift(b, 1'b0);
      host.close_frame();
      if (latch && WP_N) guard = b[3:2];
      latch = 1'b0;
   endtask

   task automatic mwrite(input logic [8:0] addr, input int n);
      logic [8:0] a;
      logic       ok;
      logic [7:0] d;
      a  = addr;
      ok = latch & WP_N;
      host.open_frame();
      host.shift({4'h0, a[8], OPC_WRITE_LOW}, 1'b0);
      host.shift(a[7:0], 1'b0);
      repeat (n) begin
         d = rnd();
         host.shift(d, 1'b0);
         if (ok && !guarded(a)) begin
            shadow[a] = d;
            a         = a + 9'h001;
         end
         else ok = 1'b0;
      end
      host.close_frame();
      latch = 1'b0;
   endtask

   task automatic mread(input logic [8:0] addr, input int n);
      logic [8:0] a;
      a = addr;
      host.open_frame();
      host.shift({4'h0, a[8], OPC_READ_LOW}, 1'b0);
      host.shift(a[7:0], 1'b0);
      repeat (n) begin
         exp_q.push_back({1'b1, shadow[a]});
         host.shift(rnd(), 1'b1);
         a = a + 9'h001;
      end
      host.close_frame();
   endtask

   // ----------------------------------------
   // Monitor
   // ----------------------------------------
   always @(posedge rx_stb) begin
      check(rx, exp_q.size() != 0 ? exp_q.pop_front() : 9'hxxx);
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed    = 32'h730C4195;
      latch   = LATCH_RESET;
      guard   = GUARD_FACTORY;
      n_fail  = 0;
      checked = 0;
      @(posedge NRST);
      #20;
      fetch();
      cmd(OPC_ARM_WRITES);
      fetch();
      cmd(OPC_DISARM_WRITES);
      fetch();
      cmd(OPC_ARM_WRITES);
      mwrite(9'h1FE, 4);
      fetch();
      mwrite(9'h1FF, 2);
      mread(9'h1FE, 4);
      @(negedge CLOCK) WP_N = 1'b0;
      cmd(OPC_ARM_WRITES);
      mwrite(9'h000, 2);
      cmd(OPC_ARM_WRITES);
      swrite(8'h0C);
      fetch();
      mread(9'h000, 2);
      @(negedge CLOCK) WP_N = 1'b1;
      cmd(OPC_ARM_WRITES);
      swrite(8'hF7);
      fetch();
      for (int g = 0; g < 4; g++) begin
         cmd(OPC_ARM_WRITES);
         swrite(8'(g) << 2);
         cmd(OPC_ARM_WRITES);
         mwrite(9'h17E, 4);
         mread(9'h17E, 4);
      end
      host.set_mode(1'b1);
      fetch();
      mread(9'h1FE, 2);
      exp_q.push_back(9'h000);
      host.open_frame();
      host.shift(8'h83, 1'b0);
      host.shift(rnd(), 1'b1);
      host.close_frame();
      complete_run();
   end

   // Generous bound: the whole sequence needs roughly 8.4 us
   initial begin
      #100000;
      n_fail++;
      complete_run();
   end
endmodule
